//--- rtl/operation_mode_controller.sv
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module operation_mode_controller
  import opmode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        wake_pin,
  input  wire logic [1:0]  direct_input_pins,
  input  wire logic        vdd_ok,
  input  wire logic        vdd_hi,
  input  wire logic        vs_uv,
  input  wire logic        vs_op,
  input  wire logic [7:0]  err_evt,
  output logic [7:0]       channel_drive,
  output logic [1:0]       op_mode,
  output logic             power_on
);

  typedef enum logic [1:0] {SLEEP, IDLE, ACTIVE, LIMP} mode_t;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == OFF_CTRL) || (a == OFF_OUT) || (a == OFF_MAP_A) ||
           (a == OFF_MAP_B) || (a == OFF_OPEN_LOAD_TEST_BITS) || (a == OFF_STATUS) ||
           (a == OFF_ERR);
  endfunction : is_mapped

  pins_t       pin_raw;
  pins_t       pin_m_r;
  pins_t       pin_s_r;
  logic [7:0]  err_m_r;
  logic [7:0]  err_s_r;
  mode_t       state_r;
  mode_t       state_nxt;
  logic        keep_active_bit_r;
  logic        soft_rst_r;
  logic [7:0]  channel_on_bits_r;
  logic [7:0]  input_map_reg_a_r;
  logic [7:0]  input_map_reg_b_r;
  logic [7:0]  open_load_test_bits_r;
  logic [7:0]  channel_error_bits_r;
  logic        uv_flag_r;
  logic        lop_flag_r;
  logic        ter_flag_r;
  logic        ter_arm_r;
  logic [7:0]  ch_r;
  logic [7:0]  ch_nxt;
  logic [1:0]  mode_r;
  logic        pwr_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        any_in;
  logic        any_out;
  logic        wr_ok;
  logic        rd_ok;
  logic        reg_clr;
  logic        flag_clr;
  logic        do_wr;
  logic        wr_en;
  logic        ar_hs;
  logic        cmd_evt;
  logic        diag_rd;
  logic        limp_entry;
  logic        operative;
  logic [7:0]  in_map;
  logic [7:0]  in_def;
  logic [7:0]  err_clr;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  // Two-stage synchronisers for pins and supply comparators
  assign pin_raw = '{wake: wake_pin, din: direct_input_pins, vdd_ok: vdd_ok,
                     vdd_hi: vdd_hi, vs_uv: vs_uv, vs_op: vs_op};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_m_r <= '0;
      pin_s_r <= '0;
      err_m_r <= '0;
      err_s_r <= '0;
    end else begin
      pin_m_r <= pin_raw;
      pin_s_r <= pin_m_r;
      err_m_r <= err_evt;
      err_s_r <= err_m_r;
    end
  end

  assign any_in    = |pin_s_r.din;
  assign any_out   = |channel_on_bits_r;
  assign operative = (state_r != SLEEP);

  always_comb begin
    state_nxt = state_r;
    if (!pin_s_r.wake) begin
      state_nxt = any_in ? LIMP : SLEEP;
    end else begin
      case (state_r)
        ACTIVE: begin
          if (!pin_s_r.vdd_ok && !any_in) begin
            state_nxt = IDLE;
          end else if (!keep_active_bit_r && !any_in && !any_out) begin
            state_nxt = IDLE;
          end else begin
            state_nxt = ACTIVE;
          end
        end
        default: begin
          state_nxt = (any_in || any_out) ? ACTIVE : IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= SLEEP;
      mode_r  <= MODE_SLEEP;
    end else begin
      state_r <= state_nxt;
      case (state_nxt)
        IDLE:    mode_r <= MODE_IDLE;
        ACTIVE:  mode_r <= MODE_ACTIVE;
        LIMP:    mode_r <= MODE_LIMP;
        default: mode_r <= MODE_SLEEP;
      endcase
    end
  end

  assign limp_entry = (state_nxt == LIMP) && (state_r != LIMP);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwr_r <= 1'b0;
    end else begin
      pwr_r <= (pin_s_r.vs_op || pin_s_r.vdd_hi) && (pin_s_r.wake || any_in);
    end
  end

  // Register access permitted per mode and logic supply
  assign wr_ok = ((state_r == IDLE) || (state_r == ACTIVE)) && pin_s_r.vdd_ok;
  assign rd_ok = wr_ok || ((state_r == LIMP) && pin_s_r.vdd_ok);
  assign reg_clr = !pin_s_r.vdd_ok || !pin_s_r.wake || soft_rst_r ||
                   (state_r == SLEEP) || (state_r == LIMP);
  assign flag_clr = (state_r == SLEEP) || !pin_s_r.vdd_ok || soft_rst_r;

  // Write channel
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready  = !w_hold_r && !bvalid_r;
  assign do_wr   = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_en   = do_wr && wr_ok && is_mapped(awaddr_r) && wstrb_r[0];
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (rd_ok && is_mapped(awaddr_r)) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel
  assign arready = !rvalid_r;
  assign ar_hs   = arvalid && arready;
  assign diag_rd = ar_hs && rd_ok && (araddr == OFF_STATUS);
  assign cmd_evt = ar_hs || (awvalid && awready);
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_comb begin
    status_word = '0;
    status_word[ST_MODE_LSB +: 2] = mode_r;
    status_word[ST_UV_BIT]        = uv_flag_r;
    status_word[ST_LOP_BIT]       = lop_flag_r;
    status_word[ST_TER_BIT]       = ter_flag_r;
    status_word[ST_ERR_LSB +: 8]  = channel_error_bits_r;
    status_word[ST_MON_LSB +: 8]  = ch_r;
    rd_word = '0;
    case (araddr)
      OFF_CTRL:   rd_word[CTRL_ACT_BIT] = keep_active_bit_r;
      OFF_OUT:    rd_word[7:0] = channel_on_bits_r;
      OFF_MAP_A:  rd_word[7:0] = input_map_reg_a_r;
      OFF_MAP_B:  rd_word[7:0] = input_map_reg_b_r;
      OFF_OPEN_LOAD_TEST_BITS:  rd_word[7:0] = open_load_test_bits_r;
      OFF_STATUS: rd_word = status_word;
      OFF_ERR:    rd_word[7:0] = channel_error_bits_r;
      default:    rd_word = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r  <= (rd_ok && is_mapped(araddr)) ? rd_word : '0;
      rresp_r  <= (rd_ok && is_mapped(araddr)) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Programmable registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      keep_active_bit_r     <= 1'b0;
      channel_on_bits_r     <= RST_OUT;
      input_map_reg_a_r     <= RST_MAP_A;
      input_map_reg_b_r     <= RST_MAP_B;
      open_load_test_bits_r <= RST_OPEN_LOAD_TEST_BITS;
    end else if (reg_clr) begin
      keep_active_bit_r     <= 1'b0;
      channel_on_bits_r     <= RST_OUT;
      input_map_reg_a_r     <= RST_MAP_A;
      input_map_reg_b_r     <= RST_MAP_B;
      open_load_test_bits_r <= RST_OPEN_LOAD_TEST_BITS;
    end else if (wr_en) begin
      case (awaddr_r)
        OFF_CTRL:  keep_active_bit_r <= wdata_r[CTRL_ACT_BIT];
        OFF_OUT:   channel_on_bits_r <= wdata_r[7:0];
        OFF_MAP_A: input_map_reg_a_r <= wdata_r[7:0];
        OFF_MAP_B: input_map_reg_b_r <= wdata_r[7:0];
        OFF_OPEN_LOAD_TEST_BITS: open_load_test_bits_r <= wdata_r[7:0];
        default:   keep_active_bit_r <= keep_active_bit_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_en && (awaddr_r == OFF_CTRL) && wdata_r[CTRL_RST_BIT];
    end
  end

  // Error bits: cleared only by write-one in Active, wiped in Sleep
  assign err_clr = (wr_en && (awaddr_r == OFF_ERR) && (state_r == ACTIVE)) ?
                   wdata_r[7:0] : 8'h00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channel_error_bits_r <= '0;
    end else if (state_r == SLEEP) begin
      channel_error_bits_r <= '0;
    end else begin
      channel_error_bits_r <= (channel_error_bits_r & ~err_clr) | err_s_r;
    end
  end

  // Supply flags, set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uv_flag_r <= 1'b0;
    end else if (limp_entry || (operative && pin_s_r.vs_uv)) begin
      uv_flag_r <= 1'b1;
    end else if (flag_clr || (diag_rd && pin_s_r.vs_op && !pin_s_r.vs_uv)) begin
      uv_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lop_flag_r <= 1'b0;
    end else if (limp_entry || (operative && pin_s_r.vdd_ok && !pin_s_r.vdd_hi)) begin
      lop_flag_r <= 1'b1;
    end else if (flag_clr || (diag_rd && pin_s_r.vdd_hi)) begin
      lop_flag_r <= 1'b0;
    end
  end

  // Transmission error: armed on Limp Home entry, also bad addresses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ter_arm_r <= 1'b0;
    end else if (limp_entry) begin
      ter_arm_r <= 1'b1;
    end else if (cmd_evt || state_r != LIMP) begin
      ter_arm_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ter_flag_r <= 1'b0;
    end else if ((ter_arm_r && cmd_evt) || (ar_hs && !is_mapped(araddr)) ||
                 (do_wr && !is_mapped(awaddr_r))) begin
      ter_flag_r <= 1'b1;
    end else if ((state_r == SLEEP) || !pin_s_r.vdd_ok || diag_rd) begin
      ter_flag_r <= 1'b0;
    end
  end

  // Channel drive follows next state, so it moves with op_mode
  assign in_map = (pin_s_r.din[0] ? input_map_reg_a_r : 8'h00) |
                  (pin_s_r.din[1] ? input_map_reg_b_r : 8'h00);
  assign in_def = (pin_s_r.din[0] ? RST_MAP_A : 8'h00) |
                  (pin_s_r.din[1] ? RST_MAP_B : 8'h00);

  always_comb begin
    case (state_nxt)
      ACTIVE: begin
        if (pin_s_r.vs_uv) begin
          ch_nxt = 8'h00;
        end else if (!pin_s_r.vdd_ok) begin
          ch_nxt = in_map;
        end else begin
          ch_nxt = channel_on_bits_r | in_map;
        end
      end
      LIMP:    ch_nxt = pin_s_r.vs_uv ? 8'h00 : (in_def & LIMP_MASK);
      default: ch_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch_r <= '0;
    end else begin
      ch_r <= ch_nxt;
    end
  end

  assign channel_drive = ch_r;
  assign op_mode       = mode_r;
  assign power_on      = pwr_r;

endmodule : operation_mode_controller

//--- inc/opmode_pkg.sv
package opmode_pkg;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_OUT    = 8'h04;
  localparam logic [7:0] OFF_MAP_A  = 8'h08;
  localparam logic [7:0] OFF_MAP_B  = 8'h0C;
  localparam logic [7:0] OFF_OPEN_LOAD_TEST_BITS  = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_ERR    = 8'h18;

  localparam int CTRL_ACT_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int ST_MODE_LSB  = 0;
  localparam int ST_UV_BIT    = 2;
  localparam int ST_LOP_BIT   = 3;
  localparam int ST_TER_BIT   = 4;
  localparam int ST_ERR_LSB   = 8;
  localparam int ST_MON_LSB   = 16;

  localparam logic [7:0] RST_OUT   = 8'h00;
  localparam logic [7:0] RST_MAP_A = 8'h04;
  localparam logic [7:0] RST_MAP_B = 8'h08;
  localparam logic [7:0] RST_OPEN_LOAD_TEST_BITS = 8'h00;
  localparam logic [7:0] LIMP_MASK = 8'h0C;

  localparam logic [1:0] MODE_IDLE   = 2'h0;
  localparam logic [1:0] MODE_LIMP   = 2'h1;
  localparam logic [1:0] MODE_ACTIVE = 2'h2;
  localparam logic [1:0] MODE_SLEEP  = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       wake;
    logic [1:0] din;
    logic       vdd_ok;
    logic       vdd_hi;
    logic       vs_uv;
    logic       vs_op;
  } pins_t;

endpackage : opmode_pkg

//--- tb/operation_mode_controller_sva.sv
`timescale 1ns/1ps
module mode_sva
  import opmode_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic [7:0]  channel_drive,
  input wire logic [1:0]  op_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sleep_off_a: assert property (op_mode == MODE_SLEEP |-> channel_drive == 8'h00)
    else $error("channel on in sleep");
  idle_off_a: assert property (op_mode == MODE_IDLE |-> channel_drive == 8'h00)
    else $error("channel on in idle");
  limp_mask_a: assert property (op_mode == MODE_LIMP |-> (channel_drive & ~LIMP_MASK) == 8'h00)
    else $error("limp drives a locked channel");
  sleep_read_a: assert property ($rose(rvalid) && $past(op_mode) == MODE_SLEEP
    && op_mode == MODE_SLEEP |-> rresp == RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("sleep read not refused");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response late");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  wr_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  rd_block_a: assert property (rvalid |-> !arready)
    else $error("read taken during response");

  cover property (op_mode == MODE_ACTIVE);
  cover property (op_mode == MODE_LIMP);
  cover property (bvalid && bresp == RESP_SLVERR);
endmodule : mode_sva

bind operation_mode_controller mode_sva i_mode_sva (.*);

//--- tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  int hangs = 0;
  initial begin
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
    {bready, rready} = 2'h3;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        return;
      end
    end
    hangs++;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        return;
      end
    end
    hangs++;
  endtask : rd
endmodule : host_model

//--- tb/tb_operation_mode_controller.sv
`timescale 1ns/1ps
module tb_operation_mode_controller;
  import opmode_pkg::*;
  typedef struct packed {
    pins_t      p;
    logic [1:0] mode;
    logic [7:0] ch;
    logic       pon;
  } row_t;
  localparam row_t ROWS [8] = '{
    {1'b1, 2'b00, 4'b1101, MODE_IDLE, 8'h00, 1'b1},
    {1'b1, 2'b01, 4'b1101, MODE_ACTIVE, 8'h04, 1'b1},
    {1'b1, 2'b10, 4'b1101, MODE_ACTIVE, 8'h08, 1'b1},
    {1'b1, 2'b00, 4'b1101, MODE_IDLE, 8'h00, 1'b1},
    {1'b0, 2'b01, 4'b1101, MODE_LIMP, 8'h04, 1'b1},
    {1'b0, 2'b11, 4'b1101, MODE_LIMP, 8'h0c, 1'b1},
    {1'b0, 2'b11, 4'b1111, MODE_LIMP, 8'h00, 1'b1},
    {1'b0, 2'b00, 4'b1101, MODE_SLEEP, 8'h00, 1'b0}
  };
  logic [7:0]  awaddr, araddr, err_evt, channel_drive;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, direct_input_pins, op_mode;
  logic        clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, wake_pin, vdd_ok, vdd_hi;
  logic        vs_uv, vs_op, power_on;
  pins_t       p;
  int          checks = 0;
  int          n_errors = 0;
  assign {wake_pin, direct_input_pins, vdd_ok, vdd_hi, vs_uv, vs_op} = p;
  operation_mode_controller i_operation_mode_controller (.*);
  host_model i_host_model (.*);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic go(input pins_t v);
    p <= v;
    repeat (8) @(posedge clk);
  endtask : go
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_host_model.wr(a, d, r);
    chk(r, er);
    repeat (8) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    i_host_model.rd(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask : rd
  function automatic logic [31:0] st(logic [1:0] m, logic [2:0] f, logic [7:0] e, mon);
    return {8'h00, mon, e, 3'b000, f, m};
  endfunction : st
  task automatic summarize;
    n_errors += i_host_model.hangs;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    rstn = 1'b0;
    err_evt = 8'h00;
    p = 7'h00;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    chk(op_mode, MODE_SLEEP);
    chk({channel_drive, power_on}, 9'h000);
    rd(OFF_OUT, 32'h0000_0000, RESP_SLVERR);
    $display("test reset done");
    foreach (ROWS[i]) begin
      go(ROWS[i].p);
      chk(op_mode, ROWS[i].mode);
      chk(channel_drive, ROWS[i].ch);
      chk(power_on, ROWS[i].pon);
    end
    $display("test rows done");
    go({1'b1, 2'b00, 4'b1101});
    wr(OFF_OUT, 32'h0000_0021, RESP_OKAY);
    chk({op_mode, channel_drive}, {MODE_ACTIVE, 8'h21});
    err_evt <= 8'h80;
    wr(OFF_OUT, 32'h0000_0000, RESP_OKAY);
    err_evt <= 8'h00;
    chk(op_mode, MODE_IDLE);
    rd(OFF_STATUS, st(MODE_IDLE, 3'b000, 8'h80, 8'h00), RESP_OKAY);
    wr(OFF_ERR, 32'h0000_0080, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
    wr(OFF_OUT, 32'h0000_0001, RESP_OKAY);
    wr(OFF_OUT, 32'h0000_0000, RESP_OKAY);
    chk({op_mode, channel_drive}, {MODE_ACTIVE, 8'h00});
    wr(OFF_CTRL, 32'h0000_0003, RESP_OKAY);
    chk(op_mode, MODE_IDLE);
    rd(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    rd(OFF_STATUS, st(MODE_IDLE, 3'b000, 8'h80, 8'h00), RESP_OKAY);
    $display("test keep and soft reset done");
    wr(OFF_MAP_A, 32'h0000_0000, RESP_OKAY);
    wr(OFF_MAP_B, 32'h0000_0000, RESP_OKAY);
    go({1'b1, 2'b01, 4'b1101});
    chk({op_mode, channel_drive}, {MODE_ACTIVE, 8'h00});
    wr(OFF_CTRL, 32'h0000_0002, RESP_OKAY);
    rd(OFF_MAP_A, {24'h00_0000, RST_MAP_A}, RESP_OKAY);
    chk(channel_drive, 8'h04);
    go({1'b1, 2'b00, 4'b1101});
    $display("test mapping done");
    wr(OFF_OUT, 32'h0000_0001, RESP_OKAY);
    go({1'b1, 2'b00, 4'b1010});
    chk(channel_drive, 8'h00);
    rd(OFF_STATUS, st(MODE_ACTIVE, 3'b011, 8'h80, 8'h00), RESP_OKAY);
    go({1'b1, 2'b00, 4'b1101});
    rd(OFF_STATUS, st(MODE_ACTIVE, 3'b011, 8'h80, 8'h01), RESP_OKAY);
    rd(OFF_STATUS, st(MODE_ACTIVE, 3'b000, 8'h80, 8'h01), RESP_OKAY);
    wr(8'h1c, 32'h0000_0000, RESP_SLVERR);
    rd(OFF_STATUS, st(MODE_ACTIVE, 3'b100, 8'h80, 8'h01), RESP_OKAY);
    go({1'b1, 2'b00, 4'b0001});
    chk({op_mode, channel_drive}, {MODE_IDLE, 8'h00});
    rd(OFF_OUT, 32'h0000_0000, RESP_SLVERR);
    $display("test supplies done");
    go({1'b1, 2'b00, 4'b1101});
    wr(OFF_OPEN_LOAD_TEST_BITS, 32'h0000_0033, RESP_OKAY);
    go({1'b0, 2'b01, 4'b1101});
    chk({op_mode, channel_drive}, {MODE_LIMP, 8'h04});
    wr(OFF_OUT, 32'h0000_00ff, RESP_OKAY);
    rd(OFF_STATUS, st(MODE_LIMP, 3'b111, 8'h80, 8'h04), RESP_OKAY);
    rd(OFF_OUT, 32'h0000_0000, RESP_OKAY);
    rd(OFF_OPEN_LOAD_TEST_BITS, 32'h0000_0000, RESP_OKAY);
    rd(OFF_STATUS, st(MODE_LIMP, 3'b000, 8'h80, 8'h04), RESP_OKAY);
    go({1'b0, 2'b00, 4'b1101});
    chk(op_mode, MODE_SLEEP);
    $display("test limp done");
    summarize();
  end
endmodule : tb_operation_mode_controller
